//--- common/ram_loader_defines.vh
`ifndef RAM_LOADER_DEFINES_VH
`define RAM_LOADER_DEFINES_VH
// ==========================================
// address map
`define COUNT_LIMIT 8'hB0
`define RAM1_START 16'h0050
`define RAM1_END 16'h00FF
`define RAM1_SIZE 176
`define EXEC_ENTRY 16'h0051
// ==========================================
// pseudo-vector targets, three bytes each
`define VEC_SERIAL 16'h0063
`define VEC_TIMER_OVF 16'h0060
`define VEC_OUT_CMP 16'h005D
`define VEC_IN_CAP 16'h005A
`define VEC_EXT_IRQ 16'h0057
`define VEC_SOFTWARE 16'h0054
`define PSEUDO_VEC_BYTES 3
// ==========================================
// timing
`define CLK_MHZ 200
`define IDLE_TIMEOUT_US 5000
`define IDLE_TIMEOUT_CYC (`IDLE_TIMEOUT_US * `CLK_MHZ)
`define LOAD_CYCLE_MC 49
`define HANDSHAKE_OUT_DELAY_MC 5
`define RECOGNISE_WINDOW_MC 30
`define DATA_SAMPLE_MC 16
`define DATA_HOLD_MC 4
`endif

//--- src/skid_buffer.v
`timescale 1ns/1ps
// ==========================================
// two-entry buffer between byte source and ram writer
module skid_buffer #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot0; // head entry
  reg [WIDTH-1:0] slot1; // second entry
  reg [1:0] count; // entries held
  wire push;
  wire pop;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage and occupancy
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      count <= 2'd0;
    end else begin
      if (pop) begin
        // shift second entry forward, or take new word
        slot0 <= (count == 2'd2) ? slot1 : in_data;
        if (push && count == 2'd2) slot1 <= in_data;
      end else if (push) begin
        if (count == 2'd0) slot0 <= in_data;
        else slot1 <= in_data;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- src/bootstrap_ram_loader.v
`timescale 1ns/1ps
`include "ram_loader_defines.vh"
// Behaviour
// [R01] first byte below B0 counts RAM bytes
// [R02] oversized count ignored, fill all regions
// [R03] extended load runs at 0051 when full/idle
// [R04] host pads stack area with no-ops
// [R05] vectors redirect to three-byte RAM slots
// [R06] fixed pseudo-vector addresses per interrupt source
// [R07] strap pattern 110 jumps straight to RAM
// [R08] source data valid by 16, hold 4
// [R09] parallel load cycle lasts 49 machine cycles
// [R10] handshake out at 5, source hold limit
// [R11] handshake in within 30 to count
// [R12] machine cycle is two core clocks
// [R13] looping handshake disables flow control
// [R14] idle timer restarts per byte, armed later
// [R15] write pointer advances contiguously across regions
module bootstrap_ram_loader #(
  parameter IDLE_CYCLES = `IDLE_TIMEOUT_CYC,
  parameter RAM_END = 16'h0FFF, // top of last ram region
  parameter MC_DIV = 2 // core clocks per machine cycle
) (
  input wire core_clk,
  input wire resetn,
  input wire parallel_mode, // 1: parallel pin loader, 0: serial stream
  input wire strap_sel_b,
  input wire strap_sel_c,
  input wire strap_sel_d,
  input wire rx_valid, // serial byte strobe, same clock
  input wire [7:0] rx_data,
  output wire rx_ready,
  input wire [7:0] par_data, // parallel data pins
  input wire handshake_in,
  output reg handshake_out,
  output reg [15:0] par_addr, // address shown to source
  output reg ram_we,
  output reg [15:0] ram_addr,
  output reg [7:0] ram_wdata,
  input wire [2:0] irq_src, // active interrupt source index
  output reg [15:0] vector_target,
  output reg loader_active,
  output reg exec_start,
  output reg [15:0] exec_addr
);
  // ==========================================
  // pin synchronisers
  reg [2:0] strap_s1;
  reg [2:0] strap_s2;
  reg [1:0] hs_s; // hs_s[0] first stage
  reg [7:0] pd_s1;
  reg [7:0] pd_s2;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      hs_s <= 2'h0;
      pd_s1 <= 8'h00;
      pd_s2 <= 8'h00;
    end else begin
      strap_s1 <= {strap_sel_d, strap_sel_c, strap_sel_b};
      strap_s2 <= strap_s1;
      hs_s <= {hs_s[0], handshake_in};
      pd_s1 <= par_data;
      pd_s2 <= pd_s1;
    end
  end
  wire hs_in = hs_s[1];
  // ==========================================
  // states
  localparam ST_STRAP = 6'b000001; // read synchronised straps, pick load path
  localparam ST_FIRST = 6'b000010; // first serial byte
  localparam ST_LOAD = 6'b000100; // serial data bytes
  localparam ST_PAR = 6'b001000; // parallel load cycles
  localparam ST_RUN = 6'b010000; // handed over to loaded code
  localparam ST_INIT = 6'b100000; // strap settle
  reg [5:0] state;
  reg [7:0] count_left; // bytes still due in counted mode
  reg extended; // count ignored, fill all regions
  reg [31:0] idle_cnt;
  reg got_byte;
  reg [1:0] settle;
  reg [7:0] mc_cnt; // machine cycles in parallel load cycle
  reg [7:0] div_cnt;
  reg hs_seen; // handshake edge seen in window
  reg hs_last;
  wire buf_valid;
  wire [7:0] buf_data;
  wire ram_last = (ram_addr == RAM_END); // pointer sits on the last ram byte
  // load end conditions; no byte is taken as a load ends, so none lands past it
  wire counted_done = !extended && (count_left == 8'h00 || ram_addr == `RAM1_END);
  wire extended_done = extended && ((ram_we && ram_last) || idle_cnt >= IDLE_CYCLES - 1);
  wire buf_ready = (state == ST_FIRST) ||
                   ((state == ST_LOAD) && !counted_done && !extended_done);
  // ==========================================
  // byte buffer
  skid_buffer #(.WIDTH(8)) u_buf (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );
  wire take = buf_valid && buf_ready;
  wire mc_tick = (div_cnt == MC_DIV - 1); // [R12]
  // ==========================================
  // pseudo-vector lookup, active while loader owns the map
  always @* begin
    case (irq_src) // [R05] [R06]
      3'd0: vector_target = `VEC_SERIAL;
      3'd1: vector_target = `VEC_TIMER_OVF;
      3'd2: vector_target = `VEC_OUT_CMP;
      3'd3: vector_target = `VEC_IN_CAP;
      3'd4: vector_target = `VEC_EXT_IRQ;
      default: vector_target = `VEC_SOFTWARE;
    endcase
  end
  // ==========================================
  // main sequencer
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_INIT;
      settle <= 2'd0;
      count_left <= 8'h00;
      extended <= 1'b0;
      idle_cnt <= 32'h0;
      got_byte <= 1'b0;
      mc_cnt <= 8'h00;
      div_cnt <= 8'h00;
      hs_seen <= 1'b0;
      hs_last <= 1'b0;
      handshake_out <= 1'b0;
      par_addr <= `RAM1_START;
      ram_we <= 1'b0;
      ram_addr <= `RAM1_START;
      ram_wdata <= 8'h00;
      loader_active <= 1'b1;
      exec_start <= 1'b0;
      exec_addr <= `EXEC_ENTRY;
    end else begin
      ram_we <= 1'b0;
      exec_start <= 1'b0;
      if (ram_we) ram_addr <= ram_addr + 16'h0001; // [R15]
      case (state)
        ST_INIT: begin
          settle <= settle + 2'd1;
          if (settle == 2'd3) state <= ST_STRAP;
        end
        ST_STRAP: begin
          if (strap_s2 == 3'b011) begin // [R07]
            exec_addr <= `EXEC_ENTRY;
            exec_start <= 1'b1;
            state <= ST_RUN;
          end else if (parallel_mode) begin
            state <= ST_PAR;
          end else begin
            state <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (take) begin
            got_byte <= 1'b1;
            idle_cnt <= 32'h0;
            if (buf_data < `COUNT_LIMIT) begin // [R01]
              count_left <= buf_data;
              extended <= 1'b0;
            end else begin
              extended <= 1'b1; // [R02]
              ram_we <= 1'b1;
              ram_wdata <= buf_data;
            end
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (take) begin
            idle_cnt <= 32'h0; // [R14]
            ram_we <= 1'b1;
            ram_wdata <= buf_data;
            if (!extended) count_left <= count_left - 8'h01;
          end else if (got_byte) begin
            idle_cnt <= idle_cnt + 32'h1;
          end
          if (counted_done) begin
            exec_start <= 1'b1; // counted load ends
            state <= ST_RUN;
          end else if (extended_done) begin
            exec_start <= 1'b1; // [R03]
            state <= ST_RUN;
          end
        end
        ST_PAR: begin
          div_cnt <= mc_tick ? 8'h00 : div_cnt + 8'h01;
          hs_last <= hs_in;
          if (hs_in != hs_last && mc_cnt < `RECOGNISE_WINDOW_MC) hs_seen <= 1'b1; // [R11]
          if (mc_tick) begin
            mc_cnt <= mc_cnt + 8'h01;
            if (mc_cnt == `HANDSHAKE_OUT_DELAY_MC - 1)
              handshake_out <= ~handshake_out; // [R10] [R13]
            // data is taken only once the handshake came back inside the window
            if ((mc_cnt == `DATA_SAMPLE_MC + `DATA_HOLD_MC - 1) && hs_seen) begin // [R08] [R11]
              ram_we <= 1'b1;
              ram_wdata <= pd_s2;
            end
            if (mc_cnt == `LOAD_CYCLE_MC - 1) begin // [R09]
              mc_cnt <= 8'h00;
              hs_seen <= 1'b0;
              par_addr <= ram_addr;
              if (ram_addr > RAM_END) begin
                exec_start <= 1'b1;
                state <= ST_RUN;
              end
            end
          end
        end
        ST_RUN: begin
          loader_active <= 1'b1; // pseudo-vectors stay mapped
        end
        default: state <= ST_INIT;
      endcase
    end
  end
endmodule

//--- verification/loader_asserts.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the loader
module loader_asserts (
  input wire core_clk, resetn, parallel_mode, strap_sel_b, strap_sel_c, strap_sel_d,
  input wire rx_valid, rx_ready, handshake_in, handshake_out, ram_we, loader_active,
  input wire exec_start,
  input wire [7:0] rx_data, par_data, ram_wdata,
  input wire [2:0] irq_src,
  input wire [15:0] par_addr, ram_addr, vector_target, exec_addr
);
  reg hs_q; // handshake out, one clock late
  reg seen; // a toggle was seen in parallel mode
  reg [7:0] gap; // clocks since the last toggle
  wire tog = handshake_out != hs_q; // toggle seen this clock
  // ==========================================
  // toggle spacing counter
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hs_q <= 1'b0;
      seen <= 1'b0;
      gap <= 8'h00;
    end else begin
      hs_q <= handshake_out;
      seen <= parallel_mode & (seen | tog);
      gap <= tog ? 8'h00 : gap + 8'h01;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  vec_serial_a: assert property (irq_src == 3'h0 |-> vector_target == 16'h0063)
    else $error("serial vector wrong");
  vec_soft_a: assert property (irq_src == 3'h5 |-> vector_target == 16'h0054)
    else $error("software vector wrong");
  exec_pulse_a: assert property (exec_start |=> !exec_start)
    else $error("run pulse too long");
  exec_entry_a: assert property (exec_start |-> exec_addr == 16'h0051)
    else $error("run address wrong");
  ptr_step_a: assert property (ram_we |=> ram_addr == $past(ram_addr) + 16'h0001)
    else $error("pointer did not step");
  run_stop_a: assert property (exec_start |=> !ram_we)
    else $error("ram written after run");
  cycle_len_a: assert property (parallel_mode && tog && seen |-> gap == 8'h61)
    else $error("load cycle length wrong");
  sample_wr_a: assert property (parallel_mode && tog |-> ##[28:40] ram_we)
    else $error("no write after handshake");
endmodule
bind bootstrap_ram_loader loader_asserts chk (.core_clk, .resetn, .parallel_mode,
  .strap_sel_b, .strap_sel_c, .strap_sel_d, .rx_valid, .rx_ready, .handshake_in,
  .handshake_out, .ram_we, .loader_active, .exec_start, .rx_data, .par_data, .ram_wdata,
  .irq_src, .par_addr, .ram_addr, .vector_target, .exec_addr);

//--- verification/parallel_source.sv
`timescale 1ns/1ps
// ==========================================
// parallel byte source without flow control
module parallel_source (
  input wire core_clk,
  input wire [15:0] par_addr,
  input wire handshake_out,
  output reg [7:0] par_data,
  output wire handshake_in
);
  reg [15:0] seen_addr = 16'h0000; // address last presented
  reg [3:0] settle = 4'h0; // clocks since the address changed
  initial par_data = 8'h3C;
  // handshake looped straight back
  assign handshake_in = handshake_out;
  // junk until 8 clocks after an address, then held data
  always @(posedge core_clk) begin
    if (par_addr !== seen_addr) begin
      seen_addr <= par_addr;
      settle <= 4'h0;
      par_data <= ~par_data;
    end else if (settle < 4'h8) begin
      settle <= settle + 4'h1;
      par_data <= ~par_data;
    end else begin
      par_data <= par_addr[7:0] ^ 8'hA5;
    end
  end
endmodule

//--- verification/bootstrap_ram_loader_test.sv
`timescale 1ns/1ps
// ==========================================
// loader testbench
module bootstrap_ram_loader_test;
  reg core_clk = 1'b0, resetn = 1'b0, parallel_mode = 1'b0, rx_valid = 1'b0;
  reg strap_sel_b = 1'b0, strap_sel_c = 1'b0, strap_sel_d = 1'b0;
  reg [7:0] rx_data = 8'h00;
  reg [2:0] irq_src = 3'h0;
  reg [15:0] exp; // expected vector
  wire rx_ready, handshake_in, handshake_out, ram_we, loader_active, exec_start;
  wire [7:0] par_data, ram_wdata;
  wire [15:0] par_addr, ram_addr, vector_target, exec_addr;
  integer fail_count = 0, check_count = 0, cycles = 0, nwr = 0, nexec = 0, i;
  reg [15:0] wa [0:15]; // logged write addresses
  reg [7:0] wd [0:15]; // logged write data
  integer wt [0:15]; // clock of each write
  always #2.5 core_clk = ~core_clk;
  bootstrap_ram_loader #(.IDLE_CYCLES(50), .RAM_END(16'h0057)) dut (.core_clk, .resetn,
    .parallel_mode, .strap_sel_b, .strap_sel_c, .strap_sel_d, .rx_valid, .rx_data, .rx_ready,
    .par_data, .handshake_in, .handshake_out, .par_addr, .ram_we, .ram_addr, .ram_wdata,
    .irq_src, .vector_target, .loader_active, .exec_start, .exec_addr);
  parallel_source src (.core_clk, .par_addr, .handshake_out, .par_data, .handshake_in);
  // log writes and run pulses, cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (ram_we === 1'b1 && nwr < 16) begin
      wa[nwr] <= ram_addr;
      wd[nwr] <= ram_wdata;
      wt[nwr] <= cycles;
      nwr <= nwr + 1;
    end
    if (exec_start === 1'b1) nexec <= nexec + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end
  task cmp(input [15:0] got, input [15:0] want);
    begin
      check_count = check_count + 1;
      if (got !== want) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task restart(input [2:0] straps, input mode);
    begin
      @(posedge core_clk);
      resetn <= 1'b0;
      {strap_sel_d, strap_sel_c, strap_sel_b} <= straps;
      parallel_mode <= mode;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      nwr <= 0;
      nexec <= 0;
      repeat (10) @(posedge core_clk);
    end
  endtask
  // hold one byte until taken
  task send(input [7:0] b);
    begin
      rx_data <= b;
      rx_valid <= 1'b1;
      @(posedge core_clk);
      while (rx_ready !== 1'b1) @(posedge core_clk);
    end
  endtask
  task pause(input integer n);
    begin
      rx_valid <= 1'b0;
      repeat (n) @(posedge core_clk);
    end
  endtask
  task t_vectors;
    for (i = 0; i < 8; i = i + 1) begin
      irq_src <= i[2:0];
      @(posedge core_clk);
      #1;
      exp = i == 0 ? 16'h0063 : i == 1 ? 16'h0060 : i == 2 ? 16'h005D : i == 3 ? 16'h005A
        : i == 4 ? 16'h0057 : 16'h0054;
      cmp(vector_target, exp);
    end
  endtask
  task t_counted;
    begin
      restart(3'h0, 1'b0);
      send(8'h03);
      for (i = 0; i < 3; i = i + 1) send(8'h11 * (i + 1));
      pause(12);
      cmp(nwr, 3);
      for (i = 0; i < 3; i = i + 1) begin
        cmp(wa[i], 16'h0050 + i);
        cmp(wd[i], 8'h11 * (i + 1));
      end
    end
  endtask
  task t_full;
    begin
      restart(3'h0, 1'b0);
      for (i = 0; i < 8; i = i + 1) send(8'hB0 + i);
      pause(12);
      cmp(nwr, 8);
      cmp(wa[7], 16'h0057);
      cmp(wd[0], 8'hB0);
      cmp(nexec, 1);
    end
  endtask
  task t_idle;
    begin
      restart(3'h0, 1'b0);
      pause(60);
      cmp(nexec, 0);
      send(8'hC0);
      send(8'hC1);
      pause(30);
      cmp(nexec, 0);
      pause(40);
      cmp(nexec, 1);
    end
  endtask
  task t_strap;
    begin
      restart(3'h3, 1'b0);
      pause(10);
      cmp(nexec, 1);
      cmp(exec_addr, 16'h0051);
      cmp(loader_active, 1);
    end
  endtask
  task t_parallel;
    begin
      restart(3'h0, 1'b1);
      pause(354);
      cmp(wt[2] - wt[1], 98);
      cmp(wa[0], 16'h0050);
      cmp(wd[1], 8'h51 ^ 8'hA5);
      cmp(wa[1], 16'h0051);
      cmp(par_addr, 16'h0053);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    t_vectors;
    $display("vectors done");
    t_counted;
    $display("counted load done");
    t_full;
    $display("full load done");
    t_idle;
    $display("idle run done");
    t_strap;
    $display("strap jump done");
    t_parallel;
    $display("parallel load done");
    print_verdict;
  end
endmodule
